// ### scfg_switch_config_slave.sv
// Purpose: Serial slave and management slave to switch registers
// Assumes: Link clocks are oversampled, at least four clk_i per half
// Notes: Register store is 256 bytes plus per-port standard words
`timescale 1ns/1ps
`default_nettype none
`include "scfg_defines.svh"
module scfg_switch_config_slave #(
  parameter int INIT_CYCLES = `SCFG_INIT_CYCLES
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [1:0] config_port_strap_i,
  input wire logic serial_select_n_i,
  input wire logic serial_clock_in_i,
  input wire logic serial_data_in_i,
  output logic serial_data_out_o,
  output logic serial_data_oe_o,
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_o,
  output logic start_switch_o,
  output logic [1:0] spi_speed_o
);

  localparam int CW = $clog2(INIT_CYCLES + 1);

  if (INIT_CYCLES < 1) begin : g_chk
    $error("INIT_CYCLES must be at least one");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Burst address step, wraps within 0..127
  function automatic logic [6:0] scfg_inc(input logic [6:0] a);
    return 7'(a + 7'h01);
  endfunction

  // Standard register slot: valid bit and index
  function automatic logic [3:0] scfg_std_slot(input logic [4:0] ra);
    logic [3:0] s;
    s = 4'h0;
    if (ra <= `SCFG_STD_LAST) s = {1'b1, ra[2:0]};
    else if (ra == `SCFG_STD_REG_A) s = 4'he;
    else if (ra == `SCFG_STD_REG_B) s = 4'hf;
    return s;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [6:0] pin_lvl;
  logic [6:0] pin_rise;
  logic [6:0] pin_fall;

  scfg_sync #(.WIDTH(7), .RESET_VAL(7'h11)) u_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .async_i({config_port_strap_i, mdio_i, mdc_i, serial_data_in_i,
              serial_clock_in_i, serial_select_n_i}),
    .level_o(pin_lvl),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  wire logic sclk_rise = pin_rise[1];
  wire logic sclk_fall = pin_fall[1];
  wire logic sdi = pin_lvl[2];
  wire logic mdc_rise = pin_rise[3];
  wire logic mdio_in = pin_lvl[4];
  // Serial slave active only with the slave strap and select low
  wire logic spi_on = (pin_lvl[6:5] == `SCFG_STRAP_SPI) & ~pin_lvl[0];

  // ----------------------------------------------------------------
  // Start-up hold
  // ----------------------------------------------------------------
  logic [CW-1:0] init_cnt_reg;
  logic init_done_reg;

  // Counts out the hold time after reset
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      init_cnt_reg <= '0;
      init_done_reg <= 1'b0;
    end else if (ce_i && !init_done_reg) begin
      init_cnt_reg <= CW'(init_cnt_reg + 1'b1);
      init_done_reg <= (init_cnt_reg == CW'(INIT_CYCLES - 1));
    end
  end

  // ----------------------------------------------------------------
  // Serial slave port
  // ----------------------------------------------------------------
  scfg_pkg::scfg_spi_state_t spi_state_reg;
  logic [2:0] spi_bit_reg;
  logic [7:0] spi_sr_reg;
  logic spi_rd_reg;
  logic [6:0] spi_addr_reg;
  logic [7:0] spi_tx_reg;
  logic spi_tx_on_reg;
  logic [7:0] mem_reg [0:255];

  // Byte assembly and phase decode
  wire logic [7:0] spi_byte = {spi_sr_reg[6:0], sdi};
  wire logic spi_done = sclk_rise & (spi_bit_reg == 3'h7);
  wire logic spi_clear = sys_rst_i | (ce_i & ~spi_on);
  wire logic spi_cmd_ok = (spi_byte == `SCFG_CMD_READ) |
                          (spi_byte == `SCFG_CMD_WRITE);
  wire logic spi_data_done = spi_done & (spi_state_reg == scfg_pkg::SPI_DATA);
  wire logic spi_wr_en = ce_i & spi_on & spi_data_done & ~spi_rd_reg;
  wire logic [7:0] spi_wr_addr = {1'b0, spi_addr_reg};
  wire logic [6:0] spi_addr_inc = scfg_inc(spi_addr_reg);

  // Shift in on rising edges, step phases per byte
  always_ff @(posedge clk_i) begin
    if (spi_clear) begin
      spi_state_reg <= scfg_pkg::SPI_CMD;
      spi_bit_reg <= 3'h0;
      spi_sr_reg <= 8'h00;
      spi_rd_reg <= 1'b0;
      spi_addr_reg <= 7'h00;
    end else if (ce_i && sclk_rise) begin
      spi_sr_reg <= spi_byte;
      spi_bit_reg <= 3'(spi_bit_reg + 3'h1);
      if (spi_done) begin
        case (spi_state_reg)
          scfg_pkg::SPI_CMD: begin
            spi_rd_reg <= (spi_byte == `SCFG_CMD_READ);
            spi_state_reg <= spi_cmd_ok ? scfg_pkg::SPI_ADDR
                                        : scfg_pkg::SPI_HALT;
          end
          scfg_pkg::SPI_ADDR: begin
            spi_addr_reg <= spi_byte[6:0];
            spi_state_reg <= scfg_pkg::SPI_DATA;
          end
          scfg_pkg::SPI_DATA: spi_addr_reg <= spi_addr_inc;
          default: spi_state_reg <= scfg_pkg::SPI_HALT;
        endcase
      end
    end
  end

  // Read byte loading and falling-edge launch
  always_ff @(posedge clk_i) begin
    if (spi_clear) begin
      spi_tx_reg <= 8'h00;
      spi_tx_on_reg <= 1'b0;
      serial_data_out_o <= 1'b0;
      serial_data_oe_o <= 1'b0;
    end else if (ce_i) begin
      serial_data_oe_o <= spi_tx_on_reg;
      if (spi_done && spi_state_reg == scfg_pkg::SPI_ADDR && spi_rd_reg) begin
        spi_tx_reg <= mem_reg[{1'b0, spi_byte[6:0]}];
        spi_tx_on_reg <= 1'b1;
      end else if (spi_data_done && spi_rd_reg) begin
        spi_tx_reg <= mem_reg[{1'b0, spi_addr_inc}];
      end else if (sclk_fall && spi_tx_on_reg) begin
        serial_data_out_o <= spi_tx_reg[7];
        spi_tx_reg <= {spi_tx_reg[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // Management slave
  // ----------------------------------------------------------------
  scfg_pkg::scfg_md_state_t md_state_reg;
  logic [5:0] md_pre_reg;
  logic [3:0] md_cnt_reg;
  logic [15:0] md_sr_reg;
  logic [1:0] md_op_reg;
  logic [4:0] md_phy_reg;
  logic [4:0] md_ra_reg;
  logic md_rd_reg;
  logic md_ext_reg;
  logic md_hit_reg;
  logic md_wr_reg;
  logic [15:0] md_wdata_reg;
  logic [15:0] std_mem_reg [0:127];

  // Header fields: start bit, opcode, PHY, register
  wire logic [12:0] md_hdr = {md_sr_reg[11:0], mdio_in};
  wire logic [1:0] hdr_op = md_hdr[11:10];
  wire logic [4:0] hdr_phy = md_hdr[9:5];
  wire logic [4:0] hdr_ra = md_hdr[4:0];
  wire logic hdr_ext = (hdr_phy[2:1] == `SCFG_EXT_SEL);
  wire logic [3:0] hdr_slot = scfg_std_slot(hdr_ra);
  wire logic hdr_std_hit = hdr_slot[3] & (hdr_phy[2:0] != 3'h0);
  wire logic hdr_ok = md_hdr[12] &
                      ((hdr_op == `SCFG_OP_READ) | (hdr_op == `SCFG_OP_WRITE));

  // Register targets of the latched frame
  wire logic [7:0] md_ext_addr = {md_phy_reg[4], md_phy_reg[3],
                                  md_phy_reg[0], md_ra_reg};
  wire logic [3:0] md_slot = scfg_std_slot(md_ra_reg);
  wire logic [6:0] md_std_idx = {md_phy_reg[3:0], md_slot[2:0]};
  wire logic [15:0] md_rdata = md_ext_reg ? {8'h00, mem_reg[md_ext_addr]}
                             : std_mem_reg[md_std_idx];
  wire logic [15:0] md_wbits = {md_sr_reg[14:0], mdio_in};

  // Frame sequencer, one step per rising MDC
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      md_state_reg <= scfg_pkg::MD_PRE;
      md_pre_reg <= 6'h00;
      md_cnt_reg <= 4'h0;
      md_sr_reg <= 16'h0000;
      md_op_reg <= 2'h0;
      md_phy_reg <= 5'h00;
      md_ra_reg <= 5'h00;
      md_rd_reg <= 1'b0;
      md_ext_reg <= 1'b0;
      md_hit_reg <= 1'b0;
      md_wr_reg <= 1'b0;
      md_wdata_reg <= 16'h0000;
      mdio_o <= 1'b0;
      mdio_oe_o <= 1'b0;
    end else if (ce_i) begin
      md_wr_reg <= 1'b0;
      if (mdc_rise) begin
        case (md_state_reg)
          scfg_pkg::MD_PRE: begin
            md_cnt_reg <= 4'h0;
            if (mdio_in) begin
              if (md_pre_reg != `SCFG_PREAMBLE_LEN)
                md_pre_reg <= 6'(md_pre_reg + 6'h01);
            end else begin
              md_pre_reg <= 6'h00;
              if (md_pre_reg == `SCFG_PREAMBLE_LEN)
                md_state_reg <= scfg_pkg::MD_HDR;
            end
          end
          scfg_pkg::MD_HDR: begin
            md_sr_reg <= {md_sr_reg[14:0], mdio_in};
            md_cnt_reg <= 4'(md_cnt_reg + 4'h1);
            if (md_cnt_reg == 4'hc) begin
              md_op_reg <= hdr_op;
              md_phy_reg <= hdr_phy;
              md_ra_reg <= hdr_ra;
              md_rd_reg <= (hdr_op == `SCFG_OP_READ);
              md_ext_reg <= hdr_ext;
              md_hit_reg <= hdr_ext | hdr_std_hit;
              md_cnt_reg <= 4'h0;
              md_state_reg <= hdr_ok ? scfg_pkg::MD_TA : scfg_pkg::MD_PRE;
            end
          end
          scfg_pkg::MD_TA: begin
            md_cnt_reg <= 4'h1;
            if (md_cnt_reg == 4'h0) begin
              // Second turnaround bit driven low on a read
              mdio_o <= 1'b0;
              mdio_oe_o <= md_rd_reg & md_hit_reg;
            end else begin
              md_cnt_reg <= 4'h0;
              md_sr_reg <= md_rdata;
              mdio_o <= md_rdata[15];
              md_state_reg <= md_rd_reg ? scfg_pkg::MD_RDATA
                                        : scfg_pkg::MD_WDATA;
            end
          end
          scfg_pkg::MD_RDATA: begin
            md_cnt_reg <= 4'(md_cnt_reg + 4'h1);
            mdio_o <= md_sr_reg[14];
            md_sr_reg <= {md_sr_reg[14:0], 1'b0};
            if (md_cnt_reg == 4'hf) begin
              mdio_o <= 1'b0;
              mdio_oe_o <= 1'b0;
              md_state_reg <= scfg_pkg::MD_PRE;
            end
          end
          default: begin
            md_cnt_reg <= 4'(md_cnt_reg + 4'h1);
            md_sr_reg <= md_wbits;
            if (md_cnt_reg == 4'hf) begin
              md_wr_reg <= md_hit_reg;
              md_wdata_reg <= md_wbits;
              md_state_reg <= scfg_pkg::MD_PRE;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Register store
  // ----------------------------------------------------------------
  // Serial port has priority over the management port
  wire logic md_ext_wr = md_wr_reg & md_ext_reg;
  wire logic wr_en = spi_wr_en | md_ext_wr;
  wire logic [7:0] wr_addr = spi_wr_en ? spi_wr_addr : md_ext_addr;
  wire logic [7:0] wr_raw = spi_wr_en ? spi_byte : md_wdata_reg[7:0];
  wire logic start_lock = (wr_addr == `SCFG_START_REG) & ~init_done_reg;
  wire logic [7:0] wr_data = wr_raw &
                             ~({7'h00, start_lock} << `SCFG_START_BIT);

  // Byte registers, start bit locked while holding
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < 256; i++) mem_reg[i] <= `SCFG_REG_RESET;
    end else if (ce_i && wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
  end

  // Per-port standard words
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < 128; i++) std_mem_reg[i] <= 16'h0000;
    end else if (ce_i && md_wr_reg && !md_ext_reg) begin
      std_mem_reg[md_std_idx] <= md_wdata_reg;
    end
  end

  // Core-facing controls
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      start_switch_o <= 1'b0;
      spi_speed_o <= 2'h0;
    end else if (ce_i) begin
      start_switch_o <= init_done_reg &
                        mem_reg[`SCFG_START_REG][`SCFG_START_BIT];
      spi_speed_o <= mem_reg[`SCFG_SPEED_REG]
                     [`SCFG_SPEED_MSB:`SCFG_SPEED_LSB];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_start_hold: assert property (!init_done_reg |-> !start_switch_o &&
    !mem_reg[`SCFG_START_REG][`SCFG_START_BIT])
    else $error("start bit set during hold");
  a_spi_wr_cmd: assert property (spi_wr_en |-> !spi_rd_reg &&
    spi_state_reg == scfg_pkg::SPI_DATA)
    else $error("serial write without write command");
  a_spi_range: assert property (spi_wr_en |-> !spi_wr_addr[7])
    else $error("serial address above 127");
  a_spi_addr_step: assert property (ce_i && spi_on && spi_data_done
    |=> spi_addr_reg == 7'($past(spi_addr_reg) + 7'h01))
    else $error("burst address did not advance");
  a_spi_wrap: assert property (ce_i && spi_on && spi_data_done &&
    spi_addr_reg == 7'h7f |=> spi_addr_reg == 7'h00)
    else $error("burst address did not wrap");
  a_spi_deselect: assert property (ce_i && !spi_on |=>
    spi_state_reg == scfg_pkg::SPI_CMD && !serial_data_oe_o)
    else $error("transfer survived deselect");
  a_sdo_fall: assert property ($changed(serial_data_out_o) |->
    $past(sclk_fall) || $past(spi_clear))
    else $error("serial output moved off falling edge");
  a_spi_rise: assert property ($changed(spi_bit_reg) |->
    $past(sclk_rise) || $past(spi_clear))
    else $error("serial bit count moved off rising edge");
  a_md_ta_zero: assert property (md_state_reg == scfg_pkg::MD_TA &&
    md_cnt_reg == 4'h1 |-> !mdio_o)
    else $error("turnaround bit not zero");
  a_md_rd_drive: assert property (mdio_oe_o |-> md_rd_reg &&
    md_op_reg == `SCFG_OP_READ)
    else $error("management line driven outside read");
  a_md_wr_op: assert property (md_wr_reg |->
    md_op_reg == `SCFG_OP_WRITE)
    else $error("management write without write opcode");
  a_md_std_only: assert property (md_wr_reg && !md_ext_reg |->
    md_slot[3])
    else $error("standard write to absent register");
  a_md_preamble: assert property (md_state_reg == scfg_pkg::MD_HDR &&
    $past(md_state_reg) == scfg_pkg::MD_PRE |->
    $past(md_pre_reg) == `SCFG_PREAMBLE_LEN)
    else $error("frame started without full preamble");
  a_md_hi_zero: assert property (md_ext_reg && mdio_oe_o &&
    md_state_reg == scfg_pkg::MD_RDATA && md_cnt_reg < 4'h8 |-> !mdio_o)
    else $error("extended read upper byte not zero");
  a_md_after_rise: assert property ($changed(mdio_oe_o) |->
    $past(mdc_rise))
    else $error("management enable moved off rising MDC");

  c_spi_burst_rd: cover property (spi_data_done && spi_rd_reg ##[1:400]
    spi_data_done && spi_rd_reg);
  c_spi_wr: cover property (spi_wr_en);
  c_md_ext_rd: cover property (mdio_oe_o && md_ext_reg);
  c_md_std_wr: cover property (md_wr_reg && !md_ext_reg);

endmodule
`default_nettype wire

// ### scfg_defines.svh
// Purpose: Constants for the switch configuration serial slave block
// Assumes: 100 MHz system clock, byte-wide configuration registers
// Notes: Offsets, field positions and timing counts live here
`ifndef SCFG_DEFINES_SVH
`define SCFG_DEFINES_SVH

// ----------------------------------------------------------------
// Serial slave port
// ----------------------------------------------------------------
`define SCFG_CMD_READ 8'h03
`define SCFG_CMD_WRITE 8'h02
`define SCFG_STRAP_SPI 2'h2
`define SCFG_SPI_CLK_DEF_KHZ 12500
`define SCFG_SPI_CLK_FAST_KHZ 25000

// ----------------------------------------------------------------
// Switch registers used by this block
// ----------------------------------------------------------------
`define SCFG_START_REG 8'h01
`define SCFG_START_BIT 0
`define SCFG_SPEED_REG 8'h0c
`define SCFG_SPEED_MSB 5
`define SCFG_SPEED_LSB 4
`define SCFG_REG_RESET 8'h00

// ----------------------------------------------------------------
// Management frame
// ----------------------------------------------------------------
`define SCFG_PREAMBLE_LEN 6'h20
`define SCFG_OP_READ 2'h2
`define SCFG_OP_WRITE 2'h1
`define SCFG_EXT_SEL 2'h3
`define SCFG_STD_LAST 5'h05
`define SCFG_STD_REG_A 5'h1d
`define SCFG_STD_REG_B 5'h1f
`define SCFG_MDC_MAX_KHZ 10000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SCFG_CLK_MHZ 100
`define SCFG_INIT_TIME_US 100
`define SCFG_INIT_CYCLES (`SCFG_INIT_TIME_US * `SCFG_CLK_MHZ)

`endif

// ### scfg_pkg.sv
// Purpose: Types shared by the switch configuration slave
// Assumes: Constants come from scfg_defines.svh
// Notes: State enumerations only
package scfg_pkg;

  // Serial slave byte phases
  typedef enum logic [1:0] {
    SPI_CMD, SPI_ADDR, SPI_DATA, SPI_HALT
  } scfg_spi_state_t;

  // Management frame phases
  typedef enum logic [2:0] {
    MD_PRE, MD_HDR, MD_TA, MD_RDATA, MD_WDATA
  } scfg_md_state_t;

endpackage

// ### scfg_sync.sv
// Purpose: Two-stage synchroniser with edge detection
// Assumes: Inputs are asynchronous to clk_i
// Notes: Stage one feeds stage two only
`timescale 1ns/1ps
`default_nettype none
module scfg_sync #(
  parameter int WIDTH = 7,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] level_o,
  output logic [WIDTH-1:0] rise_o,
  output logic [WIDTH-1:0] fall_o
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] prev_reg;

  if (WIDTH < 1) begin : g_chk
    $error("scfg_sync needs at least one bit");
  end

  // Synchroniser chain and history stage
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      meta_reg <= RESET_VAL;
      sync_reg <= RESET_VAL;
      prev_reg <= RESET_VAL;
    end else if (ce_i) begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Edge pulses from settled stages only
  assign level_o = sync_reg;
  assign rise_o = sync_reg & ~prev_reg;
  assign fall_o = ~sync_reg & prev_reg;

endmodule
`default_nettype wire

// ### scfg_host_model.sv
// Purpose: Host model for the serial and management ports
// Assumes: Tasks called from the bench, outputs move on clk_i edges
// Notes: Management line pulled up, serial data pulled up when undriven
`timescale 1ns/1ps
`default_nettype none
module scfg_host_model (
  input wire logic clk_i,
  input wire logic sdo_i,
  input wire logic sdo_oe_i,
  input wire logic mdio_dev_i,
  input wire logic mdio_oe_i,
  output logic sel_n_o,
  output logic sclk_o,
  output logic sdi_o,
  output logic mdc_o,
  output logic mdio_o
);
  logic hoe = 1'b0;
  logic hval = 1'b1;
  // Resolved management line seen by both sides
  assign mdio_o = mdio_oe_i ? mdio_dev_i : (hoe ? hval : 1'b1);
  initial begin
    sel_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
    mdc_o = 1'b0;
  end
  // Half clock period, well under both speed limits
  task automatic half();
    #58;
    @(posedge clk_i);
  endtask
  task automatic spi_begin();
    sel_n_o <= 1'b0;
    half();
  endtask
  // Select high between commands
  task automatic spi_end();
    half();
    sel_n_o <= 1'b1;
    half();
    half();
  endtask
  // One byte, MSB first, data set before rise
  task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sdi_o <= tx[i];
      half();
      sclk_o <= 1'b1;
      #1 rx[i] = sdo_oe_i ? sdo_i : 1'b1;
      half();
      sclk_o <= 1'b0;
    end
  endtask
  // One bit, host changes while clock low, samples at rise
  task automatic md_bit(input logic v, input logic drv, output logic r);
    hval <= v;
    hoe <= drv;
    half();
    mdc_o <= 1'b1;
    #1 r = mdio_o;
    half();
    mdc_o <= 1'b0;
  endtask
  // Whole frame with fresh preamble
  task automatic md_frame(input logic [1:0] op, input logic [4:0] phy,
      input logic [4:0] ra, input logic [15:0] wd,
      output logic [15:0] rd, output logic ta);
    logic [45:0] hdr;
    logic r;
    hdr = {32'hffffffff, 2'h1, op, phy, ra};
    for (int i = 45; i >= 0; i--) md_bit(hdr[i], 1'b1, r);
    if (op == 2'h1) begin
      md_bit(1'b1, 1'b1, r);
      md_bit(1'b0, 1'b1, ta);
    end else begin
      md_bit(1'b1, 1'b0, r);
      md_bit(1'b1, 1'b0, ta);
    end
    for (int i = 15; i >= 0; i--) md_bit(wd[i], op == 2'h1, rd[i]);
    md_bit(1'b1, 1'b0, r);
  endtask
endmodule
`default_nettype wire

// ### scfg_switch_config_slave_tb.sv
// Purpose: Self-checking bench for the configuration slave
// Assumes: Short start hold through INIT_CYCLES
// Notes: Byte model of the register store predicts every byte-register read
`timescale 1ns/1ps
`default_nettype none
module scfg_switch_config_slave_tb;
  localparam int HOLD = 500;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [1:0] strap = 2'h2;
  logic sel_n, sclk, sdi, sdo, sdo_oe, mdc, mdio_w, mdo, mdo_oe, start;
  logic [1:0] speed;
  int n_fail = 0;
  int cmp_count = 0;
  logic [7:0] model [256];
  logic [7:0] wbuf [8];
  logic [7:0] a, d, hi;
  logic [15:0] r16, w16;
  logic ta;
  realtime hold_end;
  always #5 clk_i = ~clk_i;
  scfg_switch_config_slave #(.INIT_CYCLES(HOLD)) u_dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1),
    .config_port_strap_i(strap), .serial_select_n_i(sel_n),
    .serial_clock_in_i(sclk), .serial_data_in_i(sdi),
    .serial_data_out_o(sdo), .serial_data_oe_o(sdo_oe),
    .mdc_i(mdc), .mdio_i(mdio_w), .mdio_o(mdo), .mdio_oe_o(mdo_oe),
    .start_switch_o(start), .spi_speed_o(speed));
  scfg_host_model u_host (
    .clk_i(clk_i), .sdo_i(sdo), .sdo_oe_i(sdo_oe), .mdio_dev_i(mdo),
    .mdio_oe_i(mdo_oe), .sel_n_o(sel_n), .sclk_o(sclk), .sdi_o(sdi),
    .mdc_o(mdc), .mdio_o(mdio_w));
  task automatic stop_test();
    if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (e !== g) begin
      n_fail++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // Serial transfer, model updated or compared per byte
  task automatic spi(input logic [7:0] cmd, input logic [7:0] ad, int n);
    logic [7:0] r;
    logic [6:0] p;
    u_host.spi_begin();
    u_host.spi_byte(cmd, r);
    u_host.spi_byte(ad, r);
    for (int i = 0; i < n; i++) begin
      p = ad[6:0] + 7'(i);
      u_host.spi_byte(wbuf[i], r);
      if (cmd == 8'h02 && strap == 2'h2) begin
        model[p] = wbuf[i];
        if (p == 7'h01 && $realtime < hold_end) model[p][0] = 1'b0;
      end
      if (cmd == 8'h03) check(model[p], r);
    end
    u_host.spi_end();
  endtask
  task automatic ext(input logic [7:0] ad);
    logic [4:0] phy;
    w16 = {hi, d};
    phy = {ad[7:6], 2'h3, ad[5]};
    u_host.md_frame(2'h1, phy, ad[4:0], w16, r16, ta);
    model[ad] = d;
    u_host.md_frame(2'h2, phy, ad[4:0], 16'h0000, r16, ta);
    check({8'h00, model[ad]}, r16);
    check(16'h0000, {15'h0000, ta});
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(46));
    foreach (model[i]) model[i] = 8'h00;
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    hold_end = $realtime + HOLD * 10;
    check(16'h0000, {start, speed, sdo_oe, mdo_oe});
    wbuf[0] = 8'h01;
    spi(8'h02, 8'h01, 1);
    check(16'h0000, start);
    foreach (wbuf[i]) wbuf[i] = 8'($urandom);
    spi(8'h02, 8'h7d, 4);
    // Hold is over: the masked start write must not show
    check(16'h0000, start);
    spi(8'h03, 8'h7d, 4);
    spi(8'h02, 8'h85, 1);
    spi(8'h03, 8'h05, 1);
    wbuf[0] = ~wbuf[0];
    spi(8'h0b, 8'h05, 1);
    spi(8'h03, 8'h05, 1);
    strap <= 2'h0;
    spi(8'h02, 8'h05, 1);
    strap <= 2'h2;
    spi(8'h03, 8'h05, 1);
    spi(8'h02, 8'h0c, 1);
    check(model[12][5:4], speed);
    wbuf[0] = 8'h01;
    spi(8'h02, 8'h01, 1);
    check(16'h0001, start);
    for (int k = 0; k < 5; k++) begin
      a = (k == 0) ? 8'hff : (k == 1) ? 8'h40 : 8'($urandom);
      d = 8'($urandom);
      hi = 8'($urandom);
      ext(a);
    end
    spi(8'h03, 8'h40, 1);
    w16 = 16'($urandom);
    u_host.md_frame(2'h1, 5'h01, 5'h1d, w16, r16, ta);
    u_host.md_frame(2'h2, 5'h01, 5'h1d, 16'h0000, r16, ta);
    check(w16, r16);
    u_host.md_frame(2'h2, 5'h01, 5'h06, 16'h0000, r16, ta);
    check(16'hffff, r16);
    stop_test();
  end
  // Watchdog, several times the expected run length
  initial begin
    #600us;
    n_fail++;
    stop_test();
  end
endmodule
`default_nettype wire
